// ---- design/cid_fsk_gen.sv ----
// Caller ID FSK generator: registers, message RAM, framing and line output
`timescale 1ns/1ps
module cid_fsk_gen
  import cid_pkg::*;
#(
  parameter int BAUD_CYCLES = BAUD_CYC
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  input  wire logic        i_reg_wr,
  input  wire logic [4:0]  i_reg_idx,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  input  wire logic        i_ram_wr,
  input  wire logic [5:0]  i_ram_addr,
  input  wire logic [7:0]  i_ram_wdata,
  output logic      [7:0]  o_ram_rdata,
  input  wire logic        i_line_ready,
  output logic             o_tone_on,
  output logic             o_line_bit,
  output logic      [11:0] o_tone_hz,
  output logic      [3:0]  o_chan_sel,
  output logic             o_busy
);

  // Register file
  logic [7:0] flag_len_field_r;
  logic [7:0] byte_count_field_r;
  logic [7:0] seizure_len_field_r;
  logic [7:0] mark_len_field_r;
  logic       modulator_enable_r;
  logic [1:0] channel_select_r;
  logic       standard_select_r;
  logic       transmit_start_r;
  logic       mark_after_send_r;
  logic [7:0] message_ram [RAM_DEPTH];

  wire wr_flag  = i_reg_wr && (i_reg_idx == REG_FLAG_IDX);
  wire wr_count = i_reg_wr && (i_reg_idx == REG_COUNT_IDX);
  wire wr_seize = i_reg_wr && (i_reg_idx == REG_SEIZE_IDX);
  wire wr_mark  = i_reg_wr && (i_reg_idx == REG_MARK_IDX);
  wire wr_ctrl  = i_reg_wr && (i_reg_idx == REG_CTRL_IDX);

  wire [7:0] ctrl_view = {2'b00, mark_after_send_r, transmit_start_r, standard_select_r,
                          channel_select_r, modulator_enable_r};
  wire [7:0] rd_sel = (i_reg_idx == REG_FLAG_IDX)  ? flag_len_field_r :
                      (i_reg_idx == REG_COUNT_IDX) ? byte_count_field_r :
                      (i_reg_idx == REG_SEIZE_IDX) ? seizure_len_field_r :
                      (i_reg_idx == REG_MARK_IDX)  ? mark_len_field_r :
                      (i_reg_idx == REG_CTRL_IDX)  ? ctrl_view : 8'h00;

  // Sequencer state
  cid_state_type state_r;
  cid_state_type state_nxt;
  logic [8:0]    cnt_r;
  logic [8:0]    cnt_nxt;
  logic [6:0]    byte_idx_r;
  logic [6:0]    byte_idx_nxt;
  logic [2:0]    bit_idx_r;
  logic [2:0]    bit_idx_nxt;
  logic          fin;
  logic          push_bit;

  cid_sym_if sym_if ();

  // Counts above the RAM size are clamped to a full RAM
  wire [6:0] nbytes      = (byte_count_field_r > {1'b0, MAX_BYTES}) ? MAX_BYTES
                                                                    : byte_count_field_r[6:0];
  wire [8:0] seize_bits  = {seizure_len_field_r, 1'b0};
  wire [6:0] byte_next   = byte_idx_r + 7'h01;
  wire       is_idle     = (state_r == ST_IDLE);
  wire       is_hold     = (state_r == ST_HOLD);
  // Start is acted on only from idle or hold, never in the middle of a transfer
  wire       go          = transmit_start_r && modulator_enable_r && (is_idle || is_hold);
  wire       sending     = !is_idle && !go && modulator_enable_r;
  wire       push        = sending && sym_if.in_ready;
  wire       busy_now    = !is_idle && !is_hold;
  wire       busy_nxt    = (state_nxt != ST_IDLE) && (state_nxt != ST_HOLD);
  wire [7:0] cur_byte    = message_ram[byte_idx_r[5:0]];

  // Each phase names its successor, so zero-length phases are skipped
  wire cid_state_type fin_state   = mark_after_send_r ? ST_HOLD : ST_IDLE;  // see (RL13)
  wire cid_state_type after_mark  = (nbytes != 7'h00) ? ST_START : fin_state;  // see (RL10)
  wire cid_state_type after_seize = (mark_len_field_r != 8'h00) ? ST_MARK : after_mark;
  wire cid_state_type after_byte  = (byte_next >= nbytes) ? fin_state : ST_START;  // see (RL6)
  wire cid_state_type after_stop  = (flag_len_field_r != 8'h00) ? ST_FLAG : after_byte;

  always_comb begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    byte_idx_nxt = byte_idx_r;
    bit_idx_nxt  = bit_idx_r;
    unique case (state_r)
      ST_IDLE, ST_HOLD: begin
        if (go) begin
          cnt_nxt      = 9'h000;
          byte_idx_nxt = 7'h00;
          state_nxt    = (seizure_len_field_r != 8'h00) ? ST_SEIZE : after_seize;  // see (RL4)
        end else if (is_hold && !mark_after_send_r) begin
          state_nxt = ST_IDLE;  // see (RL13) (RL14)
        end
      end
      ST_SEIZE: begin
        if (push) begin
          cnt_nxt = cnt_r + 9'h001;
          if (cnt_r == seize_bits - 9'h001) begin  // see (RL7)
            cnt_nxt   = 9'h000;
            state_nxt = after_seize;
          end
        end
      end
      ST_MARK: begin
        if (push) begin
          cnt_nxt = cnt_r + 9'h001;
          if (cnt_r == {1'b0, mark_len_field_r} - 9'h001) begin  // see (RL8)
            cnt_nxt   = 9'h000;
            state_nxt = after_mark;
          end
        end
      end
      ST_START: begin
        if (push) begin
          bit_idx_nxt = 3'h0;
          state_nxt   = ST_DATA;
        end
      end
      ST_DATA: begin
        if (push) begin
          bit_idx_nxt = bit_idx_r + 3'h1;
          if (bit_idx_r == 3'h7) state_nxt = ST_STOP;
        end
      end
      ST_STOP: begin
        if (push) begin
          cnt_nxt   = 9'h000;
          state_nxt = after_stop;
          if (after_stop != ST_FLAG) byte_idx_nxt = byte_next;
        end
      end
      ST_FLAG: begin
        if (push) begin
          cnt_nxt = cnt_r + 9'h001;
          if (cnt_r == {1'b0, flag_len_field_r} - 9'h001) begin  // see (RL9)
            cnt_nxt      = 9'h000;
            byte_idx_nxt = byte_next;
            state_nxt    = after_byte;
          end
        end
      end
    endcase
    if (!modulator_enable_r) state_nxt = ST_IDLE;
  end

  assign fin = (busy_now || go) && !busy_nxt && modulator_enable_r;

  // Bit value of the symbol offered to the buffer
  always_comb begin
    unique case (state_r)
      ST_SEIZE: push_bit = cnt_r[0];  // see (RL7)
      ST_START: push_bit = 1'b0;  // see (RL5)
      ST_DATA:  push_bit = cur_byte[bit_idx_r];  // see (RL15)
      default:  push_bit = 1'b1;
    endcase
  end

  assign sym_if.in_valid = sending;
  assign sym_if.in_data  = {channel_select_r, standard_select_r, push_bit};

  // The buffer lets the sequencer run two symbols ahead while the line stalls
  cid_sym_buf u_buf (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_clk_en  (i_clk_en),
    .sb        (sym_if.fifo)
  );

  // Baud pacing and line stage
  logic [16:0] baud_cnt_r;
  wire         baud_tick = (baud_cnt_r == 17'(BAUD_CYCLES - 1));
  wire [SYM_W-1:0] head  = sym_if.out_data;
  wire [1:0]   head_ch   = head[SYM_CH_LO +: 2];
  wire [11:0]  head_hz   = head[SYM_STD] ? (head[SYM_BIT] ? V23_MARK_HZ : V23_SPACE_HZ)     // see (RL2)
                                         : (head[SYM_BIT] ? BELL_MARK_HZ : BELL_SPACE_HZ);  // see (RL1)
  assign sym_if.out_ready = baud_tick && i_line_ready;  // see (RL19)
  logic        line_std_r;
  // A tick with an empty buffer mutes; a stalled receiver keeps the current tone

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      baud_cnt_r <= 17'h0_0000;
      o_tone_on  <= 1'b0;
      o_line_bit <= 1'b1;
      o_tone_hz  <= 12'h000;
      o_chan_sel <= 4'h0;
      line_std_r <= 1'b0;
    end else if (i_clk_en) begin
      baud_cnt_r <= baud_tick ? 17'h0_0000 : baud_cnt_r + 17'h0_0001;
      if (baud_tick && sym_if.out_valid && i_line_ready) begin
        o_tone_on  <= 1'b1;
        o_line_bit <= head[SYM_BIT];
        o_tone_hz  <= head_hz;
        o_chan_sel <= 4'h1 << head_ch;  // see (RL3)
        line_std_r <= head[SYM_STD];
      end else if (baud_tick && !sym_if.out_valid) begin
        o_tone_on  <= 1'b0;  // see (RL13)
        o_tone_hz  <= 12'h000;
        o_chan_sel <= 4'h0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_r             <= ST_IDLE;
      cnt_r               <= 9'h000;
      byte_idx_r          <= 7'h00;
      bit_idx_r           <= 3'h0;
      flag_len_field_r    <= LEN_RST;
      byte_count_field_r  <= LEN_RST;
      seizure_len_field_r <= LEN_RST;
      mark_len_field_r    <= LEN_RST;
      modulator_enable_r  <= CTRL_RST[CTRL_EN_BIT];
      channel_select_r    <= CTRL_RST[CTRL_CH_LO +: 2];
      standard_select_r   <= CTRL_RST[CTRL_STD_BIT];
      transmit_start_r    <= CTRL_RST[CTRL_START_BIT];
      mark_after_send_r   <= CTRL_RST[CTRL_MAS_BIT];
      o_reg_rdata         <= 8'h00;
      o_ram_rdata         <= 8'h00;
      o_busy              <= 1'b0;
    end else if (i_clk_en) begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      byte_idx_r <= byte_idx_nxt;
      bit_idx_r  <= bit_idx_nxt;
      if (wr_flag) flag_len_field_r <= i_reg_wdata;
      if (wr_count) byte_count_field_r <= i_reg_wdata;
      if (wr_seize) seizure_len_field_r <= i_reg_wdata;
      if (wr_mark) mark_len_field_r <= i_reg_wdata;
      if (wr_ctrl) begin
        modulator_enable_r <= i_reg_wdata[CTRL_EN_BIT];
        channel_select_r   <= i_reg_wdata[CTRL_CH_LO +: 2];
        standard_select_r  <= i_reg_wdata[CTRL_STD_BIT];
        mark_after_send_r  <= i_reg_wdata[CTRL_MAS_BIT];
      end
      // A host write of start wins over the self-clear in the same cycle
      if (wr_ctrl) transmit_start_r <= i_reg_wdata[CTRL_START_BIT];
      else if (fin) transmit_start_r <= 1'b0;  // see (RL12)
      o_reg_rdata <= rd_sel;
      o_ram_rdata <= message_ram[i_ram_addr];
      o_busy      <= busy_nxt;
    end
  end

  for (genvar g = 0; g < RAM_DEPTH; g++) begin : g_ram
    always_ff @(posedge i_ref_clk) begin
      if (i_clk_en && i_ram_wr && (i_ram_addr == 6'(g))) message_ram[g] <= i_ram_wdata;  // see (RL11)
    end
  end

  // Checks
  default clocking cb @(posedge i_ref_clk iff i_clk_en);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_last_step;
    fin && !wr_ctrl;
  endsequence

  sequence s_last_data;
    push && state_r == ST_DATA && bit_idx_r == 3'h7;
  endsequence

  a_bell_tones: assert property (o_tone_on && !line_std_r |->  // see (RL1)
      o_tone_hz == (o_line_bit ? BELL_MARK_HZ : BELL_SPACE_HZ)) else $error("bell tone wrong");
  a_v23_tones: assert property (o_tone_on && line_std_r |->  // see (RL2)
      o_tone_hz == (o_line_bit ? V23_MARK_HZ : V23_SPACE_HZ)) else $error("v23 tone wrong");
  a_chan_onehot: assert property (o_tone_on |-> $onehot(o_chan_sel)) else $error("channel not one-hot");  // see (RL3)
  a_seize_first: assert property (go && seizure_len_field_r != 8'h00 |=> state_r == ST_SEIZE)  // see (RL4)
      else $error("seizure not first");
  a_frame_bits: assert property (push && (state_r == ST_START || state_r == ST_STOP) |->  // see (RL5)
      push_bit == (state_r == ST_STOP)) else $error("framing bit wrong");
  a_run_ones: assert property (push && (state_r inside {ST_MARK, ST_FLAG, ST_HOLD}) |-> push_bit)  // see (RL9)
      else $error("run bit not one");
  a_seize_alt: assert property (push && state_r == ST_SEIZE |-> push_bit == cnt_r[0]) else $error("seizure order");  // see (RL7)
  a_seize_len: assert property (state_r == ST_SEIZE && push && cnt_r == seize_bits - 9'h001  // see (RL7)
      |=> state_r != ST_SEIZE) else $error("seizure length");
  a_byte_limit: assert property (state_r == ST_START |-> byte_idx_r < nbytes) else $error("too many bytes");  // see (RL6)
  a_start_clear: assert property (s_last_step |=> !transmit_start_r) else $error("start not cleared");  // see (RL12)
  a_hold_needs_go: assert property (is_idle && !go |=> !is_hold) else $error("marks resumed");  // see (RL14)
  a_tone_on_tick: assert property (!$stable(o_tone_hz) |-> $past(baud_tick)) else $error("tone off boundary");  // see (RL19)
  a_stop_follows: assert property (s_last_data |=> state_r == ST_STOP)  // see (RL5)
      else $error("stop bit missing");
  a_mark_len: assert property (state_r == ST_MARK && push && cnt_r == {1'b0, mark_len_field_r} - 9'h001  // see (RL8)
      |=> state_r != ST_MARK) else $error("mark run length");
  a_flag_len: assert property (state_r == ST_FLAG && push && cnt_r == {1'b0, flag_len_field_r} - 9'h001  // see (RL9)
      |=> state_r != ST_FLAG) else $error("flag run length");
  a_mute_quiet: assert property (!o_tone_on |-> o_tone_hz == 12'h000 && o_chan_sel == 4'h0)  // see (RL13)
      else $error("muted line not quiet");
  a_empty_mutes: assert property (baud_tick && !sym_if.out_valid |=> !o_tone_on)  // see (RL13)
      else $error("empty tick not muted");
  a_byte_clamp: assert property (byte_idx_r <= MAX_BYTES) else $error("byte index past RAM");  // see (RL10)

endmodule : cid_fsk_gen

// ---- shared/cid_pkg.sv ----
// Constants, register map and types of the caller ID FSK generator
// Summary of operation
// (RL1) Standard select 0 uses 1200 Hz for ones and 2200 Hz for zeros.
// (RL2) Standard select 1 uses 1300 Hz for ones and 2100 Hz for zeros.
// (RL3) Two-bit channel select picks which of four channels carries the tones.
// (RL4) Setting start sends seizure, then mark run, then bytes, unattended.
// (RL5) Each byte goes as start 0, eight data bits, stop 1, flag ones.
// (RL6) After each flag run, repeat the byte step while bytes remain, else stop.
// (RL7) Seizure sends alternating 0 and 1, twice the seizure count bits long.
// (RL8) Mark run sends as many ones as the mark length register holds.
// (RL9) Flag run after every byte sends as many ones as flag length holds.
// (RL10) Byte count selects how many RAM bytes go out, 0 to 64 valid.
// (RL11) A 64-byte message RAM is readable and writable by the host.
// (RL12) Start bit clears itself once all programmed bytes are sent.
// (RL13) After the last byte, send continuous ones if mark-after-send, else mute.
// (RL14) Re-setting mark-after-send resumes marks only after a new start.
// (RL15) Bytes go out on the line least significant bit first.
// (RL16) Host enables the generator before start and disables it afterwards.
// (RL17) Host splits long messages into 64-byte segments, reloading after each.
// (RL18) Host keeps mark-after-send set between segments, clears it after last.
// (RL19) Each bit lasts one 1200 baud period; tones change on bit boundaries.
package cid_pkg;

  localparam logic [4:0] REG_FLAG_IDX  = 5'h13;
  localparam logic [4:0] REG_COUNT_IDX = 5'h14;
  localparam logic [4:0] REG_SEIZE_IDX = 5'h15;
  localparam logic [4:0] REG_MARK_IDX  = 5'h16;
  localparam logic [4:0] REG_CTRL_IDX  = 5'h17;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_CH_LO     = 1;
  localparam int CTRL_STD_BIT   = 3;
  localparam int CTRL_START_BIT = 4;
  localparam int CTRL_MAS_BIT   = 5;

  localparam logic [7:0] LEN_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  localparam int         RAM_DEPTH = 64;
  localparam logic [6:0] MAX_BYTES = 7'h40;

  localparam logic [11:0] BELL_MARK_HZ  = 12'h04B0;
  localparam logic [11:0] BELL_SPACE_HZ = 12'h0898;
  localparam logic [11:0] V23_MARK_HZ   = 12'h0514;
  localparam logic [11:0] V23_SPACE_HZ  = 12'h0834;

  localparam int CLK_HZ   = 32'h05F5_E100;
  localparam int BAUD_HZ  = 32'h0000_04B0;
  localparam int BAUD_CYC = CLK_HZ / BAUD_HZ;

  localparam int SYM_W      = 4;
  localparam int SYM_BIT    = 0;
  localparam int SYM_STD    = 1;
  localparam int SYM_CH_LO  = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEIZE,
    ST_MARK,
    ST_START,
    ST_DATA,
    ST_STOP,
    ST_FLAG,
    ST_HOLD
  } cid_state_type;

endpackage : cid_pkg

// ---- shared/cid_sym_if.sv ----
// Symbol handshake between the serializer and the two-entry buffer
`timescale 1ns/1ps
interface cid_sym_if;
  import cid_pkg::*;
  logic             in_valid;
  logic             in_ready;
  logic [SYM_W-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [SYM_W-1:0] out_data;

  modport src (
    output in_valid,
    output in_data,
    input  in_ready,
    input  out_valid,
    input  out_data,
    output out_ready
  );

  modport fifo (
    input  in_valid,
    input  in_data,
    output in_ready,
    output out_valid,
    output out_data,
    input  out_ready
  );
endinterface : cid_sym_if

// ---- design/cid_sym_buf.sv ----
// Two-entry symbol buffer with valid and ready on both sides
`timescale 1ns/1ps
module cid_sym_buf
  import cid_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_clk_en,
  cid_sym_if.fifo   sb
);

  logic [SYM_W-1:0] mem_r [2];
  logic             wr_ptr_r;
  logic             rd_ptr_r;
  logic [1:0]       cnt_r;
  wire              do_push = sb.in_valid && sb.in_ready;
  wire              do_pop  = sb.out_valid && sb.out_ready;

  assign sb.in_ready  = (cnt_r != 2'h2);
  assign sb.out_valid = (cnt_r != 2'h0);
  assign sb.out_data  = mem_r[rd_ptr_r];

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else if (i_clk_en) begin
      if (do_push) wr_ptr_r <= ~wr_ptr_r;
      if (do_pop) rd_ptr_r <= ~rd_ptr_r;
      cnt_r <= cnt_r + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_clk_en && do_push) mem_r[wr_ptr_r] <= sb.in_data;
  end

endmodule : cid_sym_buf

// ---- dv/cid_line_rx.sv ----
// Caller ID receiver model that samples one symbol per ready baud period; i_slow makes it ready every other period
`timescale 1ns/1ps
module cid_line_rx #(
  parameter int BAUD = 8
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_slow,
  input  wire logic        i_tone_on,
  input  wire logic        i_line_bit,
  input  wire logic [11:0] i_tone_hz,
  input  wire logic [3:0]  i_chan_sel,
  output logic             o_line_ready = 1'b1
);
  logic        bit_q[$];
  logic [11:0] hz_q[$];
  logic [3:0]  ch_q[$];
  int          cnt_r;
  logic        pend_r;
  logic        ph_r;

  // Ready moves mid-period so it is steady around every baud tick
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cnt_r        <= 0;
      pend_r       <= 1'b0;
      ph_r         <= 1'b0;
      o_line_ready <= 1'b1;
    end else begin
      cnt_r <= (cnt_r == BAUD - 1) ? 0 : cnt_r + 1;
      if (cnt_r == BAUD - 1 && o_line_ready) begin
        pend_r <= 1'b1;
      end
      if (cnt_r == BAUD / 2) begin
        ph_r         <= !ph_r;
        o_line_ready <= !(i_slow && !ph_r);
        pend_r       <= 1'b0;
        if (pend_r && i_tone_on) begin
          bit_q.push_back(i_line_bit);
          hz_q.push_back(i_tone_hz);
          ch_q.push_back(i_chan_sel);
        end
      end
    end
  end
endmodule : cid_line_rx

// ---- dv/cid_fsk_gen_tb.sv ----
// Self-checking bench: register and RAM access, framed transmissions, hold and mute
`timescale 1ns/1ps
module cid_fsk_gen_tb;
  import cid_pkg::*;
  localparam int BAUD = 8;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic        reg_wr    = 1'b0;
  logic [4:0]  reg_idx   = 5'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        ram_wr    = 1'b0;
  logic [5:0]  ram_addr  = 6'h00;
  logic [7:0]  ram_wdata = 8'h00;
  logic [7:0]  ram_rdata;
  logic        line_ready;
  logic        tone_on;
  logic        line_bit;
  logic [11:0] tone_hz;
  logic [3:0]  chan_sel;
  logic        busy;
  logic        slow      = 1'b0;
  logic [7:0]  mem [64];
  logic [7:0]  rd;
  int          bad_count = 0;
  int          n_tests   = 0;

  always #5 clk = ~clk;

  cid_fsk_gen #(.BAUD_CYCLES(BAUD)) u_cid_fsk_gen (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(1'b1), .i_reg_wr(reg_wr), .i_reg_idx(reg_idx),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_ram_wr(ram_wr), .i_ram_addr(ram_addr),
    .i_ram_wdata(ram_wdata), .o_ram_rdata(ram_rdata), .i_line_ready(line_ready), .o_tone_on(tone_on),
    .o_line_bit(line_bit), .o_tone_hz(tone_hz), .o_chan_sel(chan_sel), .o_busy(busy)
  );

  cid_line_rx #(.BAUD(BAUD)) u_cid_line_rx (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_slow(slow), .i_tone_on(tone_on), .i_line_bit(line_bit),
    .i_tone_hz(tone_hz), .i_chan_sel(chan_sel), .o_line_ready(line_ready)
  );

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] idx, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_idx   <= idx;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [4:0] idx, output logic [7:0] d);
    @(posedge clk);
    reg_idx <= idx;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask : rd_reg

  task automatic wr_ram(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    ram_wr    <= 1'b1;
    ram_addr  <= a;
    ram_wdata <= d;
    mem[a] = d;
    @(posedge clk);
    ram_wr <= 1'b0;
  endtask : wr_ram

  task automatic run(input string nm, input logic [7:0] sl, input logic [7:0] ml, input logic [7:0] n,
                     input logic [7:0] fl, input logic std, input logic [1:0] ch, input logic mas,
                     input logic sw);
    logic       q[$];
    logic [7:0] ctrl;
    int         nb;
    int         k;
    int         j;
    ctrl = {2'b00, mas, 1'b0, std, ch, 1'b1};
    nb = (n > 8'd64) ? 64 : int'(n);
    for (k = 0; k < 2 * sl; k++) q.push_back(k[0]);
    for (k = 0; k < ml; k++) q.push_back(1'b1);
    for (k = 0; k < nb; k++) begin
      q.push_back(1'b0);
      for (j = 0; j < 8; j++) q.push_back(mem[k][j]);
      q.push_back(1'b1);
      for (j = 0; j < fl; j++) q.push_back(1'b1);
    end
    slow <= sw;
    wr_reg(REG_FLAG_IDX, fl);
    wr_reg(REG_COUNT_IDX, n);
    wr_reg(REG_SEIZE_IDX, sl);
    wr_reg(REG_MARK_IDX, ml);
    wr_reg(REG_CTRL_IDX, ctrl);
    wr_reg(REG_CTRL_IDX, ctrl | 8'h10);
    for (k = 0; k <= 40000; k++) begin
      @(posedge clk);
      if (k == 40000) begin
        bad_count++;
        $display("[ERR] %0t transmission never finished", $time);
        summarize();
      end
      if (k > 4 && busy === 1'b0) break;
    end
    // Up to two buffered symbols may still drain, at half rate when the receiver stalls
    repeat (8 * BAUD) @(posedge clk);
    while (u_cid_line_rx.bit_q.size() > 0 && u_cid_line_rx.bit_q[0] === 1'b1 && q[0] === 1'b0) begin
      void'(u_cid_line_rx.bit_q.pop_front());
      void'(u_cid_line_rx.hz_q.pop_front());
      void'(u_cid_line_rx.ch_q.pop_front());
    end
    if (!mas) chk(12'(u_cid_line_rx.bit_q.size()), 12'(q.size()), "bit count");
    for (k = 0; k < u_cid_line_rx.bit_q.size(); k++) begin
      if (k >= q.size()) begin
        chk(u_cid_line_rx.bit_q[k], 12'h001, "hold mark");
      end else begin
        chk(u_cid_line_rx.bit_q[k], q[k], "line bit");
        chk(u_cid_line_rx.hz_q[k], std ? (q[k] ? V23_MARK_HZ : V23_SPACE_HZ)
            : (q[k] ? BELL_MARK_HZ : BELL_SPACE_HZ), "tone");
        chk(u_cid_line_rx.ch_q[k], {8'h00, 4'h1 << ch}, "channel");
      end
    end
    u_cid_line_rx.bit_q.delete();
    u_cid_line_rx.hz_q.delete();
    u_cid_line_rx.ch_q.delete();
    rd_reg(REG_CTRL_IDX, rd);
    chk(rd, ctrl, "start self clear");
    if (mas) begin
      chk({10'h000, tone_on, line_bit}, 12'h003, "hold");
    end else begin
      chk({7'h00, tone_on, chan_sel}, 12'h000, "mute");
      chk(tone_hz, 12'h000, "mute tone");
      wr_reg(REG_CTRL_IDX, ctrl & 8'hFE);
    end
    $display("test %s done", nm);
  endtask : run

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 19; i < 24; i++) begin
      rd_reg(5'(i), rd);
      chk(rd, 8'h00, "reset value");
    end
    chk({tone_on, line_bit}, 12'h001, "idle line");
    wr_reg(5'h05, 8'hFF);
    rd_reg(5'h05, rd);
    chk(rd, 8'h00, "unmapped");
    for (int i = 19; i < 23; i++) begin
      wr_reg(5'(i), 8'(i) ^ 8'hA5);
      rd_reg(5'(i), rd);
      chk(rd, 8'(i) ^ 8'hA5, "length reg");
    end
    wr_reg(REG_CTRL_IDX, 8'hCE);
    rd_reg(REG_CTRL_IDX, rd);
    chk(rd, 8'h0E, "control reg");
    $display("test registers done");
    for (int i = 0; i < 64; i++) wr_ram(6'(i), 8'(i * 29 + 7));
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      ram_addr <= 6'(i);
      @(posedge clk);
      #1 chk(ram_rdata, mem[i], "ram");
    end
    $display("test ram done");
    run("bell", 8'h02, 8'h03, 8'h02, 8'h01, 1'b0, 2'h2, 1'b0, 1'b0);
    run("v23 hold", 8'h01, 8'h00, 8'h03, 8'h00, 1'b1, 2'h3, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++) wr_ram(6'(i), 8'(8'h3C + i));
    run("segment two", 8'h02, 8'h01, 8'h01, 8'h02, 1'b0, 2'h0, 1'b0, 1'b0);
    wr_reg(REG_CTRL_IDX, 8'h21);
    repeat (4 * BAUD) @(posedge clk);
    chk(tone_on, 12'h000, "mark not resumed");
    wr_reg(REG_CTRL_IDX, 8'h00);
    run("full ram", 8'h00, 8'h00, 8'h41, 8'h00, 1'b1, 2'h1, 1'b0, 1'b0);
    run("empty", 8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 2'h1, 1'b0, 1'b0);
    summarize();
  end
endmodule : cid_fsk_gen_tb
